/* design/gacd_decoder.sv */
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - with split status set, 5C/58/59/5A clear ifc/srq/lockout/remote flags
// - 5E clears the sync flag, 5F sets it
// - 51 holds acceptor in not-ready, giving an rfd holdoff
// - 07 releases dac holdoff; with pass-through, byte taken as osa
// - 0F clears dac holdoff; with pass-through, byte taken as msa
// - 09 sets the parallel poll flag, 01 clears it
// - 1B pulses ltn, forces continuous holdoff until unlistened
// - 0C forces listener into idle
// - 1C forces listener idle only while controller is active
// - 0B forces talker into idle
// - 50 accepted with no effect
// - 00 pulses local pon for exactly one clock
// - 05 pulses rtl one clock unless rtl already set
// - 18/19 feed service request sync as true and false
// - 03 clears rfd holdoff state
// - 04 drives trigger output for three clocks, no flag effect
// - write with top bits 100 loads eos/holdoff config; reset 80
// - binary compare: eight bits match, else low seven bits
// - transmit-end-with-string in tacs sends eoi on matching byte
// - receive compare enables end detection on received bytes
// - holdoff mode: normal, every byte, on end, continuous
// - commands are byte writes to a write-only port, back to back
// - normal mode: end byte enters end holdoff until release
module gacd_decoder (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_end,
  input wire logic [7:0] tx_byte,
  input wire logic talker_active,
  output logic tx_eoi,
  input wire logic controller_active,
  input wire logic unaddressed_listen,
  input wire logic rtl_in,
  input wire logic set_ifc,
  input wire logic set_srq,
  input wire logic set_lok,
  input wire logic set_rem,
  input wire logic dac_event,
  output logic local_pon,
  output logic local_rtl,
  output logic local_ltn,
  output logic force_lids,
  output logic force_tids,
  output logic req_true,
  output logic req_false,
  output logic release_osa,
  output logic release_msa,
  output logic acceptor_rdy,
  output logic trigger_output
);
  logic [7:0] cfg_reg;
  logic [7:0] eos_reg;
  logic [1:0] ctrl_reg;
  logic [4:0] flags_reg;
  logic ist_reg;
  logic rfd_ho_reg;
  logic dac_ho_reg;
  logic acceptor_end_holdoff_state_reg;
  logic cont_reg;
  logic [1:0] trigger_output_reg;
  logic wr_pend_reg;
  logic [31:0] waddr_reg;
  logic [6:0] pulse_reg;
  logic osa_reg;
  logic msa_reg;

  function automatic logic eos_match(input logic [7:0] b,
      input logic [7:0] e, input logic binary_compare);
    eos_match = binary_compare ? (b == e) : (b[6:0] == e[6:0]);
  endfunction

  wire logic addr_ph = hsel && hready && htrans[1];
  wire logic [7:0] cmd = hwdata[7:0];
  wire logic aux_wr = wr_pend_reg && (waddr_reg == gacd_pkg::AUX_PORT_ADDR);
  wire logic is_cfg = aux_wr && (cmd[7:5] == gacd_pkg::CFG_SEL);
  wire logic cmd_ok = aux_wr && !is_cfg;
  wire logic split_status_select = ctrl_reg[gacd_pkg::CT_SPLIT_STATUS_SELECT];
  wire logic address_pass_through_flag = ctrl_reg[gacd_pkg::CT_APT];
  // every decode below needs an exact code match
  wire logic c_pon = cmd_ok && cmd == gacd_pkg::C_PON;
  wire logic c_ist_clr = cmd_ok && cmd == gacd_pkg::C_IST_CLR;
  wire logic c_release_holdoff_cmd = cmd_ok && cmd == gacd_pkg::C_RELEASE_HOLDOFF_CMD;
  wire logic c_trigger_output = cmd_ok && cmd == gacd_pkg::C_TRIGGER_OUTPUT;
  wire logic c_rtl = cmd_ok && cmd == gacd_pkg::C_RTL;
  wire logic c_inv = cmd_ok && cmd == gacd_pkg::C_INVALID;
  wire logic c_ist_set = cmd_ok && cmd == gacd_pkg::C_IST_SET;
  wire logic c_lut = cmd_ok && cmd == gacd_pkg::C_LUT;
  wire logic c_lul = cmd_ok && cmd == gacd_pkg::C_LUL;
  wire logic c_val = cmd_ok && cmd == gacd_pkg::C_VALID;
  wire logic c_request_true_cmd = cmd_ok && cmd == gacd_pkg::C_REQUEST_TRUE_CMD;
  wire logic c_request_false_cmd = cmd_ok && cmd == gacd_pkg::C_REQUEST_FALSE_CMD;
  wire logic c_ltn = cmd_ok && cmd == gacd_pkg::C_LISTEN_CONTINUOUS_CMD;
  wire logic c_lun = cmd_ok && cmd == gacd_pkg::C_LUN;
  wire logic c_hold_immediately_cmd = cmd_ok && cmd == gacd_pkg::C_HOLD_IMMEDIATELY_CMD;
  // the page command decodes to nothing
  wire logic [3:0] clr_int = {4{cmd_ok && split_status_select}} & {
    cmd == gacd_pkg::C_CLR_REM, cmd == gacd_pkg::C_CLR_LOK,
    cmd == gacd_pkg::C_CLR_SRQ, cmd == gacd_pkg::C_CLR_IFC};
  wire logic c_clear_sync_flag_cmd = cmd_ok && cmd == gacd_pkg::C_CLEAR_SYNC_FLAG_CMD;
  wire logic c_set_sync = cmd_ok && cmd == gacd_pkg::C_SET_SYNC;

  wire logic [1:0] cfg_mode = cfg_reg[1:0];
  wire logic [1:0] eff_mode = cont_reg ? gacd_pkg::HO_CONT : cfg_mode;
  wire logic rx_eos = rx_valid && cfg_reg[gacd_pkg::CFG_RECEIVE_STRING_COMPARE_BIT]
    && eos_match(rx_byte, eos_reg, cfg_reg[gacd_pkg::CFG_BIN_BIT]);
  // decide whether an accepted byte leaves the acceptor held off
  wire logic ho_take = rx_valid && (eff_mode == gacd_pkg::HO_ALL
    || eff_mode == gacd_pkg::HO_CONT
    || (eff_mode == gacd_pkg::HO_END && rx_eos));
  wire logic acceptor_end_holdoff_state_take = rx_valid && rx_eos
    && eff_mode == gacd_pkg::HO_NORMAL;
  wire logic [3:0] ext_set = {set_rem, set_lok, set_srq, set_ifc};
  wire logic [3:0] int_next = ext_set | (flags_reg[3:0] & ~clr_int);
  wire logic sync_next = c_set_sync
    | (flags_reg[4] & ~c_clear_sync_flag_cmd);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rx_end = rx_eos;
  assign tx_eoi = talker_active && cfg_reg[gacd_pkg::CFG_TRANSMIT_END_WITH_STRING_BIT]
    && eos_match(tx_byte, eos_reg, cfg_reg[gacd_pkg::CFG_BIN_BIT]);
  assign local_pon = pulse_reg[0];
  assign local_rtl = pulse_reg[1];
  assign local_ltn = pulse_reg[2];
  assign force_lids = pulse_reg[3];
  assign force_tids = pulse_reg[4];
  assign req_true = pulse_reg[5];
  assign req_false = pulse_reg[6];
  assign release_osa = osa_reg;
  assign release_msa = msa_reg;
  // rdy is withheld while any holdoff stands
  assign acceptor_rdy = !(rfd_ho_reg || acceptor_end_holdoff_state_reg || dac_ho_reg);
  assign trigger_output = (trigger_output_reg != 2'h0);

  wire logic [31:0] status_word = {21'h000000, acceptor_end_holdoff_state_reg ? 1'b1 : 1'b0,
    cont_reg, acceptor_end_holdoff_state_reg, dac_ho_reg, rfd_ho_reg, ist_reg, flags_reg};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 32'h00000000;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ph && hwrite;
      waddr_reg <= haddr;
      if (addr_ph && !hwrite) begin
        if (haddr == gacd_pkg::STATUS_ADDR) begin
          hrdata <= status_word;
        end else if (haddr == gacd_pkg::EOS_REG_ADDR) begin
          hrdata <= {24'h000000, eos_reg};
        end else if (haddr == gacd_pkg::CTRL_ADDR) begin
          hrdata <= {30'h00000000, ctrl_reg};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      eos_reg <= 8'h00;
      ctrl_reg <= 2'h0;
    end else begin
      if (wr_pend_reg && waddr_reg == gacd_pkg::EOS_REG_ADDR) begin
        eos_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && waddr_reg == gacd_pkg::CTRL_ADDR) begin
        ctrl_reg <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_reg <= gacd_pkg::CFG_RESET;
    end else if (is_cfg) begin
      cfg_reg <= cmd;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags_reg <= 5'h00;
      ist_reg <= 1'b0;
    end else begin
      flags_reg <= {sync_next, int_next};
      if (c_ist_set) begin
        ist_reg <= 1'b1;
      end else if (c_ist_clr) begin
        ist_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rfd_ho_reg <= 1'b0;
      acceptor_end_holdoff_state_reg <= 1'b0;
      cont_reg <= 1'b0;
      dac_ho_reg <= 1'b0;
    end else begin
      // hardware set wins over a release in the same cycle
      rfd_ho_reg <= c_hold_immediately_cmd || ho_take || (rfd_ho_reg && !c_release_holdoff_cmd);
      acceptor_end_holdoff_state_reg <= acceptor_end_holdoff_state_take || (acceptor_end_holdoff_state_reg && !c_release_holdoff_cmd);
      if (c_ltn) begin
        cont_reg <= 1'b1;
      end else if (unaddressed_listen) begin
        cont_reg <= 1'b0;
      end
      dac_ho_reg <= dac_event || (dac_ho_reg && !(c_inv || c_val));
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pulse_reg <= 7'h00;
      osa_reg <= 1'b0;
      msa_reg <= 1'b0;
      trigger_output_reg <= 2'h0;
    end else begin
      pulse_reg <= {c_request_false_cmd, c_request_true_cmd, c_lut,
        c_lul || (c_lun && controller_active),
        c_ltn, c_rtl && !rtl_in, c_pon};
      osa_reg <= c_inv && dac_ho_reg && address_pass_through_flag;
      msa_reg <= c_val && dac_ho_reg && address_pass_through_flag;
      if (c_trigger_output) begin
        trigger_output_reg <= gacd_pkg::TRIGGER_OUTPUT_LOAD;
      end else if (trigger_output_reg != 2'h0) begin
        trigger_output_reg <= trigger_output_reg - 2'h1;
      end
    end
  end
endmodule // gacd_decoder

/* design/gacd_pkg.sv */
package gacd_pkg;
  // register byte address (offset printed is not a multiple of four)
  localparam logic [7:0] AUX_PORT_IDX = 8'h0A;
  localparam logic [31:0] AUX_PORT_ADDR = 32'h00000028;
  // status register chosen for readback
  localparam logic [31:0] STATUS_ADDR = 32'h00000000;
  localparam logic [31:0] EOS_REG_ADDR = 32'h00000004;
  localparam logic [31:0] CTRL_ADDR = 32'h00000008;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [2:0] CFG_SEL = 3'h4;
  localparam int CFG_BIN_BIT = 4;
  localparam int CFG_TRANSMIT_END_WITH_STRING_BIT = 3;
  localparam int CFG_RECEIVE_STRING_COMPARE_BIT = 2;
  localparam logic [1:0] HO_NORMAL = 2'h0;
  localparam logic [1:0] HO_ALL = 2'h1;
  localparam logic [1:0] HO_END = 2'h2;
  localparam logic [1:0] HO_CONT = 2'h3;
  localparam logic [7:0] C_PON = 8'h00;
  localparam logic [7:0] C_IST_CLR = 8'h01;
  localparam logic [7:0] C_RELEASE_HOLDOFF_CMD = 8'h03;
  localparam logic [7:0] C_TRIGGER_OUTPUT = 8'h04;
  localparam logic [7:0] C_RTL = 8'h05;
  localparam logic [7:0] C_INVALID = 8'h07;
  localparam logic [7:0] C_IST_SET = 8'h09;
  localparam logic [7:0] C_LUT = 8'h0B;
  localparam logic [7:0] C_LUL = 8'h0C;
  localparam logic [7:0] C_VALID = 8'h0F;
  localparam logic [7:0] C_REQUEST_TRUE_CMD = 8'h18;
  localparam logic [7:0] C_REQUEST_FALSE_CMD = 8'h19;
  localparam logic [7:0] C_LISTEN_CONTINUOUS_CMD = 8'h1B;
  localparam logic [7:0] C_LUN = 8'h1C;
  localparam logic [7:0] C_PAGE = 8'h50;
  localparam logic [7:0] C_HOLD_IMMEDIATELY_CMD = 8'h51;
  localparam logic [7:0] C_CLR_SRQ = 8'h58;
  localparam logic [7:0] C_CLR_LOK = 8'h59;
  localparam logic [7:0] C_CLR_REM = 8'h5A;
  localparam logic [7:0] C_CLR_IFC = 8'h5C;
  localparam logic [7:0] C_CLEAR_SYNC_FLAG_CMD = 8'h5E;
  localparam logic [7:0] C_SET_SYNC = 8'h5F;
  localparam int TRIGGER_OUTPUT_CYCLES = 3;
  localparam logic [1:0] TRIGGER_OUTPUT_LOAD = 2'(TRIGGER_OUTPUT_CYCLES);
  // status register bit positions
  localparam int ST_IFC = 0;
  localparam int ST_SRQ = 1;
  localparam int ST_LOK = 2;
  localparam int ST_REM = 3;
  localparam int ST_SYNC = 4;
  localparam int ST_IST = 5;
  localparam int ST_RFDHO = 6;
  localparam int ST_DACHO = 7;
  localparam int ST_ACCEPTOR_END_HOLDOFF_STATE = 8;
  localparam int ST_CONT = 9;
  localparam int ST_RSV = 10;
  // control register bit positions
  localparam int CT_SPLIT_STATUS_SELECT = 0;
  localparam int CT_APT = 1;
endpackage

/* sim/gacd_checker.sv */
`timescale 1ns/1ps
module gacd_checker (
  input wire logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata,
  input wire logic [1:0] htrans,
  input wire logic rx_valid, rx_end, talker_active, tx_eoi, trigger_output,
  input wire logic controller_active, local_pon, local_rtl, local_ltn,
  input wire logic force_lids, force_tids, req_true, req_false, rtl_in
);
  logic wp, cv;
  logic [7:0] c, cfg;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // cv marks the cycle in which a decoded command shows at the outputs
  always_ff @(posedge clock) begin
    wp <= nrst && hsel && hready && htrans[1] && hwrite
      && haddr == gacd_pkg::AUX_PORT_ADDR;
    cv <= nrst && wp;
    c <= hwdata[7:0];
    if (!nrst)
      cfg <= gacd_pkg::CFG_RESET;
    else if (wp && hwdata[7:5] == gacd_pkg::CFG_SEL)
      cfg <= hwdata[7:0];
  end
  pon_pulse_a: assert property (
    local_pon == (cv && c == 8'h00)) else $error("pon pulse wrong");
  trigger_output_len_a: assert property (
    cv && c == 8'h04 |-> trigger_output [*3]) else $error("trigger_output short");
  trigger_output_cause_a: assert property (
    $rose(trigger_output) |-> cv && c == 8'h04) else $error("stray trigger_output");
  rtl_cause_a: assert property (
    local_rtl |-> cv && c == 8'h05) else $error("stray rtl");
  rtl_pulse_a: assert property (
    local_rtl == (cv && c == 8'h05 && !$past(rtl_in)))
    else $error("rtl pulse wrong");
  ltn_pulse_a: assert property (
    local_ltn == (cv && c == 8'h1B)) else $error("ltn wrong");
  unlisten_a: assert property (
    force_lids == (cv && (c == 8'h0C
      || c == 8'h1C && $past(controller_active)))) else $error("lids wrong");
  untalk_a: assert property (
    force_tids == (cv && c == 8'h0B)) else $error("tids wrong");
  request_a: assert property (
    {req_true, req_false} == {cv && c == 8'h18, cv && c == 8'h19})
    else $error("request wrong");
  rx_end_a: assert property (
    rx_end |-> rx_valid && cfg[gacd_pkg::CFG_RECEIVE_STRING_COMPARE_BIT]) else $error("rx end");
  tx_eoi_a: assert property (
    tx_eoi |-> talker_active && cfg[gacd_pkg::CFG_TRANSMIT_END_WITH_STRING_BIT]) else $error("eoi");
  bus_okay_a: assert property (
    hreadyout && !hresp) else $error("bus not okay");
  cover property (cv && c == 8'h04);
  cover property (rx_end);
  cover property (force_lids);
endmodule // gacd_checker
bind gacd_decoder gacd_checker i_chk (.*);

/* sim/gacd_bus_model.sv */
`timescale 1ns/1ps
module gacd_bus_model (
  input wire logic clock, rx_end, tx_eoi,
  output logic [7:0] rx_byte, tx_byte,
  output logic rx_valid, talker_active, controller_active,
  output logic unaddressed_listen, rtl_in, dac_event,
  output logic set_ifc, set_srq, set_lok, set_rem
);
  initial begin
    {rx_valid, talker_active, controller_active, unaddressed_listen} = '0;
    {rtl_in, dac_event, set_ifc, set_srq, set_lok, set_rem} = '0;
    rx_byte = 8'hA5;
    tx_byte = 8'h5A;
  end
  task automatic flags(input logic [4:0] f);
    @(posedge clock);
    {dac_event, set_rem, set_lok, set_srq, set_ifc} <= f;
    @(posedge clock);
    {dac_event, set_rem, set_lok, set_srq, set_ifc} <= 5'h00;
  endtask
  task automatic lvl(input logic [2:0] v);
    @(posedge clock);
    {controller_active, rtl_in, unaddressed_listen} <= v;
  endtask
  // released lines show the inverse so stale data never matches
  task automatic rx(input logic [7:0] b, output logic e);
    @(posedge clock);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(negedge clock);
    e = rx_end;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic tx(input logic [7:0] b, output logic e);
    @(posedge clock);
    tx_byte <= b;
    talker_active <= 1'b1;
    @(negedge clock);
    e = tx_eoi;
    @(posedge clock);
    talker_active <= 1'b0;
    tx_byte <= ~b;
  endtask
endmodule // gacd_bus_model

/* sim/gacd_decoder_test.sv */
`timescale 1ns/1ps
module gacd_decoder_test;
  logic clock, nrst, hsel, hwrite, hresp, hreadyout, e;
  logic [31:0] haddr, hwdata, hrdata, d, s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, rx_end, talker_active, tx_eoi, controller_active, rtl_in;
  logic unaddressed_listen, set_ifc, set_srq, set_lok, set_rem, dac_event;
  logic local_pon, local_rtl, local_ltn, force_lids, force_tids, req_true;
  logic req_false, release_osa, release_msa, acceptor_rdy, trigger_output;
  logic [7:0] pul[10] = '{8'h00, 8'h05, 8'h04, 8'h1B, 8'h0C, 8'h1C, 8'h0B,
    8'h18, 8'h19, 8'h50};
  logic [7:0] fc[4] = '{8'h5C, 8'h58, 8'h59, 8'h5A};
  int n_fail, checked, cyc;
  wire hready = hreadyout;
  gacd_decoder i_dut (.*);
  gacd_bus_model i_bus (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [31:0] v, x, input string n);
    checked++;
    if (v !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, x, v);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, wd);
    @(posedge clock);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    d = hrdata;
  endtask
  task automatic cmd(input logic [7:0] c);
    xfer(1'b1, gacd_pkg::AUX_PORT_ADDR, {24'h0, c});
  endtask
  task automatic rd;
    xfer(1'b0, gacd_pkg::STATUS_ADDR, 32'h0);
  endtask
  task automatic rdy(input logic x);
    @(negedge clock);
    chk(32'(acceptor_rdy), 32'(x), "rdy");
  endtask
  task automatic conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    {nrst, hwrite, hwdata, haddr} = '0;
    {hsel, htrans, hsize} = {1'b1, 2'h0, 3'h2};
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rd();
    chk(d, 32'h0, "status reset");
    rdy(1'b1);
    cmd(8'h5F);
    cmd(8'h09);
    rd();
    chk(d & 32'h30, 32'h30, "sync ist set");
    cmd(8'h5E);
    cmd(8'h01);
    rd();
    chk(d & 32'h30, 32'h0, "sync ist clear");
    xfer(1'b1, gacd_pkg::CTRL_ADDR, 32'h1);
    i_bus.flags(5'h0F);
    foreach (fc[k]) begin
      cmd(fc[k]);
      rd();
      chk(d & 32'hF, 32'hF & (32'hF << (k + 1)), "flag clear");
    end
    $display("test flags done");
    i_bus.lvl(3'b100);
    foreach (pul[k]) cmd(pul[k]);
    rd();
    chk(d & 32'h200, 32'h200, "forced cont");
    i_bus.lvl(3'b110);
    cmd(8'h05);
    i_bus.lvl(3'b001);
    i_bus.lvl(3'b000);
    cmd(8'h1C);
    rd();
    s = d;
    chk(d & 32'h200, 32'h0, "cont ended");
    cmd(8'h7E);
    rd();
    chk(d, s, "reserved code");
    $display("test pulses done");
    xfer(1'b1, gacd_pkg::EOS_REG_ADDR, 32'h8D);
    cmd(8'h94);
    i_bus.rx(8'h0D, e);
    chk(32'(e), 32'h0, "end binary");
    cmd(8'h84);
    i_bus.rx(8'h0D, e);
    chk(32'(e), 32'h1, "end ascii");
    rdy(1'b0);
    cmd(8'h03);
    rdy(1'b1);
    cmd(8'h51);
    rdy(1'b0);
    cmd(8'h03);
    rdy(1'b1);
    cmd(8'h88);
    i_bus.tx(8'h8D, e);
    chk(32'(e), 32'h1, "eoi");
    $display("test eos done");
    xfer(1'b1, gacd_pkg::CTRL_ADDR, 32'h2);
    for (int k = 0; k < 2; k++) begin
      i_bus.flags(5'h10);
      cmd(k ? 8'h0F : 8'h07);
      @(negedge clock);
      chk(32'({release_msa, release_osa}), 32'(k + 1), "release");
      rdy(1'b1);
    end
    $display("test dac done");
    conclude;
  end
endmodule // gacd_decoder_test
